/* core/cc_charger_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module cc_charger_ctrl import cc_pkg::*; #(
   parameter cc_cnt_t DGL_TICKS = DGL_T,
   parameter cc_cnt_t RST_TICKS = RST_T,
   parameter cc_cnt_t WAKE_TICKS = WAKE_T,
   parameter cc_cnt_t RECH_TICKS = RECH_T
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire cc_pins_t PINS,
   input wire logic [1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output cc_cfg_t CFG_OUT,
   output logic STATUS_FLAG_OUT,
   output logic STATUS_FLAG_OE_N,
   output logic HOST_RESET_OUT_N,
   output logic RESET_PENDING_OUT,
   output logic CHARGER_EN_OUT,
   output logic CHARGER_RESTART_OUT,
   output logic TIMER_CLEAR_OUT
);

   cc_st_t r;
   cc_st_t n;

   // ======================================================
   // Command decode shared by the wire and the bus
   function automatic cc_cfg_t apply(cc_cfg_t c, logic [4:0] k);
      cc_cfg_t o;
      logic [4:0] j;
      o = c;
      j = k - 5'h01;
      if (k != 5'h00 && k <= CMD_SW_LAST) begin
         o.sw[j[2:1]] = ~k[0];
      end
      if (k == CMD_TAP_OFF || k == CMD_TAP_ON) begin
         o.tap = (k == CMD_TAP_ON);
      end
      if (k >= CMD_EOC_OFF && k <= CMD_EOC_LAST) begin
         o.eoc = 2'(k - CMD_EOC_OFF);
      end
      if (k >= CMD_OCP_900 && k <= CMD_OCP_LAST) begin
         o.ocp = 2'(k - CMD_OCP_900);
      end
      if (k >= CMD_VFL_OFF && k <= CMD_VFL_LAST) begin
         o.vfl = 3'(k - CMD_VFL_OFF);
      end
      if (k == CMD_SHIP) begin
         o.ship = 1'b1;
      end
      if (k == CMD_AR_OFF || k == CMD_AR_ON) begin
         o.arech = (k == CMD_AR_ON);
      end
      if (k == CMD_WD_OFF || k == CMD_WD_ON) begin
         o.wdog = (k == CMD_WD_ON);
      end
      return o;
   endfunction

   logic [6:0] ev;
   assign ev = {r.f.ntc, r.f.therm, r.f.below_pre, r.f.tmo, r.f.ovchg, r.f.chrg,
      r.f.eoc};

   always_comb begin
      cc_pins_t edg;
      logic [2:0] top;
      logic tk;
      logic go;
      n = r;
      edg = r.f ^ r.fp;
      top = 3'h0;
      tk = (r.div == TICK_CYC - 8'h01);
      go = 1'b0;

      // ===================================================
      // Pin synchronisers and the 10 us tick
      // A change is taken only once stages two and three agree.
      n.s1 = PINS;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.f = (r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3));
      n.fp = r.f;
      n.div = tk ? 8'h00 : r.div + 8'h01;

      // ===================================================
      // Single-wire decoder
      // The wire idles low; a long high opens a frame and a long low closes it.
      if (edg.single_wire_protocol) begin
         if (!r.f.single_wire_protocol) begin
            if (r.sw_cnt >= START_T) begin
               n.sw_frame = 1'b1;
               n.sw_n = 5'h00;
            end else if (r.sw_frame && r.sw_n != 5'h1f) begin
               n.sw_n = r.sw_n + 5'h01;
            end
         end
         n.sw_cnt = '0;
      end else begin
         if (tk && r.sw_cnt < STOP_T) begin
            n.sw_cnt = r.sw_cnt + 19'h00001;
         end
         if (!r.f.single_wire_protocol && r.sw_frame && r.sw_cnt >= STOP_T) begin
            n.cfg = apply(r.cfg, r.sw_n);
            n.sw_frame = 1'b0;
         end
      end

      // ===================================================
      // Register bus
      // Every request is answered on the second edge; no back-to-back stall.
      n.wreq = 1'b1;
      if ((AVS_READ || AVS_WRITE) && r.wreq) begin
         n.wreq = 1'b0;
         if (AVS_READ) begin
            case (AVS_ADDRESS)
               A_CFG: n.rdata = {17'h00000, r.cfg};
               A_STAT: n.rdata = {16'h0000, r.sw_n, r.rs, r.fl_idx, r.fl_oe_n,
                  r.chg_en, r.f.vin_ok, r.pend, r.nrst};
               default: n.rdata = 32'h00000000;
            endcase
         end else if (AVS_ADDRESS == A_CFG) begin
            n.cfg = cc_cfg_t'(AVS_WRITEDATA[14:0]);
         end else if (AVS_ADDRESS == A_CMD) begin
            n.cfg = apply(r.cfg, AVS_WRITEDATA[4:0]);
         end
      end

      // ===================================================
      // Wake from shipping shutdown
      // Only counted while no valid supply, so a live input masks the pin.
      if (r.cfg.ship && !r.f.vin_ok && r.f.wake) begin
         if (tk) begin
            n.wk_cnt = r.wk_cnt + 19'h00001;
         end
         if (r.wk_cnt >= WAKE_TICKS) begin
            n.wk_cnt = '0;
            if (r.f.bat_wake_ok) begin
               n.cfg.ship = 1'b0;
            end
         end
      end else begin
         n.wk_cnt = '0;
      end

      // ===================================================
      // Charger enable and restarts
      n.restart = 1'b0;
      n.tclr = 1'b0;
      n.chg_en = r.f.charge_enable_in && !r.cfg.ship;
      if (!r.f.charge_enable_in) begin
         if (tk && r.cen_cnt < CEN_T) begin
            n.cen_cnt = r.cen_cnt + 19'h00001;
         end
      end else begin
         n.cen_cnt = '0;
      end
      if (edg.charge_enable_in && !r.f.charge_enable_in && r.f.ntc) begin
         n.tclr = 1'b1;
         n.ntc_stop = 1'b1;
      end
      if (edg.charge_enable_in && r.f.charge_enable_in) begin
         n.ntc_stop = 1'b0;
         if (!r.f.ovchg && r.cen_cnt >= CEN_T) begin
            n.restart = r.f.tmo || r.f.below_pre || r.f.eoc ||
               (r.ntc_stop && !r.f.ntc);
         end
      end
      if (r.cfg.arech && r.f.eoc && r.f.rech_low && r.f.charge_enable_in && !r.f.ovchg) begin
         if (tk) begin
            n.ar_cnt = r.ar_cnt + 19'h00001;
         end
         if (r.ar_cnt >= RECH_TICKS) begin
            n.ar_cnt = '0;
            n.restart = 1'b1;
         end
      end else begin
         n.ar_cnt = '0;
      end

      // ===================================================
      // Status flag encoder
      for (int i = 0; i < 7; i++) begin
         if (ev[i]) begin
            top = 3'(i);
         end
      end
      if (!r.f.vin_ok) begin
         n.fl_oe_n = 1'b1;
         n.fl_cnt = '0;
      end else if (ev == 7'h00) begin
         n.fl_oe_n = 1'b0;
         n.fl_cnt = '0;
      end else if (top != r.fl_idx) begin
         n.fl_idx = top;
         n.fl_cnt = '0;
         n.fl_oe_n = 1'b0;
      end else if (tk) begin
         n.fl_cnt = r.fl_cnt + 19'h00001;
         if (r.fl_cnt >= HALF_T[r.fl_idx] - 19'h00001) begin
            n.fl_cnt = '0;
            n.fl_oe_n = ~r.fl_oe_n;
         end
      end

      // ===================================================
      // Smart reset and watchdog
      // This path never touches charger state, so resets cannot disturb charging.
      if (tk) begin
         n.rs_cnt = r.rs_cnt + 19'h00001;
      end
      case (r.rs)
         RS_IDLE: begin
            n.rs_cnt = '0;
            if (r.cfg.wdog) begin
               n.rs = RS_WDOG;
            end else if (r.f.vin_ok) begin
               n.rs = RS_DGL;
            end
         end
         RS_DGL: begin
            if (!r.f.vin_ok) begin
               n.rs = RS_IDLE;
            end else if (r.rs_cnt >= DGL_TICKS) begin
               n.rs = RS_PEND;
               n.pend = 1'b1;
               n.rs_cnt = '0;
            end
         end
         RS_PEND: begin
            if (!r.f.vin_ok && !r.cfg.wdog) begin
               n.rs = RS_IDLE;
               n.pend = 1'b0;
            end else if (!r.cfg.wdog && r.f.kick) begin
               go = 1'b1;
            end else if (r.rs_cnt >= RST_TICKS) begin
               if (r.cfg.wdog && r.f.kick) begin
                  n.rs = RS_WDOG;
                  n.pend = 1'b0;
                  n.rs_cnt = '0;
               end else begin
                  go = 1'b1;
               end
            end
         end
         RS_PULSE: begin
            // The count runs on into the next watchdog period, so pulses recur fall to fall.
            if (r.rs_cnt >= (r.f.vin_ok ? PV_T : PB_T)) begin
               n.nrst = 1'b1;
               n.rs = r.cfg.wdog ? RS_WDOG : RS_DONE;
            end
         end
         RS_DONE: begin
            n.rs_cnt = '0;
            if (r.cfg.wdog) begin
               n.rs = RS_WDOG;
            end else if (!r.f.vin_ok) begin
               n.rs = RS_IDLE;
            end
         end
         RS_WDOG: begin
            if (r.rs_cnt >= RST_TICKS) begin
               n.rs_cnt = '0;
               go = !r.f.kick;
            end
         end
         default: begin
            n.rs = RS_IDLE;
         end
      endcase
      if (go) begin
         n.rs = RS_PULSE;
         n.pend = 1'b0;
         n.nrst = 1'b0;
         n.rs_cnt = '0;
      end
      if (r.cfg.wdog && !n.cfg.wdog) begin
         n.rs = RS_IDLE;
         n.pend = 1'b0;
         n.nrst = 1'b1;
         n.rs_cnt = '0;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         r <= '0;
         r.cfg <= CFG_RST;
         r.nrst <= 1'b1;
         r.fl_oe_n <= 1'b1;
         r.wreq <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign AVS_READDATA = r.rdata;
   assign AVS_WAITREQUEST = r.wreq;
   assign CFG_OUT = r.cfg;
   assign STATUS_FLAG_OUT = 1'b0;
   assign STATUS_FLAG_OE_N = r.fl_oe_n;
   assign HOST_RESET_OUT_N = r.nrst;
   assign RESET_PENDING_OUT = r.pend;
   assign CHARGER_EN_OUT = r.chg_en;
   assign CHARGER_RESTART_OUT = r.restart;
   assign TIMER_CLEAR_OUT = r.tclr;

   // ======================================================
   // Checks
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_flag_released: assert property (!r.f.vin_ok |=> r.fl_oe_n)
      else $error("flag driven without valid supply");
   a_flag_low_idle: assert property (r.f.vin_ok && ev == 7'h00 |=> !r.fl_oe_n)
      else $error("flag not low when idle");
   a_flag_eoc_rate: assert property (r.f.vin_ok && ev == 7'h01 |=> r.fl_idx == 3'h0)
      else $error("end of charge rate wrong");
   a_flag_tmo_rate: assert property (r.f.vin_ok && ev[6:3] == 4'h1 |=> r.fl_idx == 3'h3)
      else $error("timeout rate wrong");
   a_flag_ntc_only: assert property (r.f.vin_ok && r.f.ntc |=> r.fl_idx == 3'h6)
      else $error("temperature pattern not exclusive");
   a_cen_disables: assert property (!r.f.charge_enable_in |=> !r.chg_en)
      else $error("charger enabled with enable low");
   a_ovchg_no_restart: assert property (r.f.ovchg |=> !r.restart)
      else $error("restart during overcharge");
   a_ntc_timer_clear: assert property ($fell(r.f.charge_enable_in) && r.f.ntc |=> r.tclr)
      else $error("timers not cleared");
   a_pend_after_dgl: assert property ($rose(r.pend) |-> $past(r.rs) == RS_DGL)
      else $error("pending rose early");
   a_pulse_width: assert property ($fell(r.nrst) |=> !r.nrst [*8])
      else $error("host reset pulse too short");
   a_wdog_off: assert property ($fell(r.cfg.wdog) |-> r.rs == RS_IDLE && r.nrst)
      else $error("watchdog disable left state");
   a_wdog_skip: assert property (r.rs == RS_WDOG && r.f.kick |=> r.nrst)
      else $error("kick did not skip pulse");

   c_host_reset: cover property ($fell(r.nrst));
   c_restart: cover property (r.restart);
   c_wake: cover property ($fell(r.cfg.ship));
   c_flag_toggle: cover property (r.f.vin_ok && $rose(r.fl_oe_n));

endmodule
`default_nettype wire

/* core/cc_pkg.sv */
package cc_pkg;
   typedef logic [18:0] cc_cnt_t;

   // ======================================================
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int TICK_US = 10;
   localparam logic [7:0] TICK_CYC = 8'(CLK_HZ / 1000000 * TICK_US);
   localparam int TPS = 1000000 / TICK_US;
   localparam int T_DGL_MS = 150;
   localparam int T_RST_MS = 4000;
   localparam int T_WAKE_MS = 1200;
   localparam int T_RECH_MS = 1200;
   localparam int T_CEN_MS = 15;
   localparam int T_START_US = 300;
   localparam int T_STOP_US = 500;
   localparam int T_PV_US = 25;
   localparam int T_PB_US = 50;
   localparam cc_cnt_t DGL_T = cc_cnt_t'(T_DGL_MS * (TPS / 1000));
   localparam cc_cnt_t RST_T = cc_cnt_t'(T_RST_MS * (TPS / 1000));
   localparam cc_cnt_t WAKE_T = cc_cnt_t'(T_WAKE_MS * (TPS / 1000));
   localparam cc_cnt_t RECH_T = cc_cnt_t'(T_RECH_MS * (TPS / 1000));
   localparam cc_cnt_t CEN_T = cc_cnt_t'(T_CEN_MS * (TPS / 1000));
   localparam cc_cnt_t START_T = cc_cnt_t'((T_START_US + TICK_US - 1) / TICK_US);
   localparam cc_cnt_t STOP_T = cc_cnt_t'((T_STOP_US + TICK_US - 1) / TICK_US);
   localparam cc_cnt_t PV_T = cc_cnt_t'((T_PV_US + TICK_US - 1) / TICK_US);
   localparam cc_cnt_t PB_T = cc_cnt_t'((T_PB_US + TICK_US - 1) / TICK_US);
   // Flag rates in tenths of a hertz, lowest first; half period = TPS*5/rate.
   localparam int RATE_DHZ [7] = '{41, 62, 82, 102, 128, 142, 162};
   localparam cc_cnt_t HALF_T [7] = '{cc_cnt_t'(TPS * 5 / RATE_DHZ[0]),
      cc_cnt_t'(TPS * 5 / RATE_DHZ[1]), cc_cnt_t'(TPS * 5 / RATE_DHZ[2]),
      cc_cnt_t'(TPS * 5 / RATE_DHZ[3]), cc_cnt_t'(TPS * 5 / RATE_DHZ[4]),
      cc_cnt_t'(TPS * 5 / RATE_DHZ[5]), cc_cnt_t'(TPS * 5 / RATE_DHZ[6])};

   // ======================================================
   // Pulse-count commands and register words
   localparam logic [4:0] CMD_SW_LAST = 5'h08;
   localparam logic [4:0] CMD_TAP_OFF = 5'h09;
   localparam logic [4:0] CMD_TAP_ON = 5'h0a;
   localparam logic [4:0] CMD_EOC_OFF = 5'h0b;
   localparam logic [4:0] CMD_EOC_LAST = 5'h0d;
   localparam logic [4:0] CMD_OCP_900 = 5'h0e;
   localparam logic [4:0] CMD_OCP_LAST = 5'h11;
   localparam logic [4:0] CMD_VFL_OFF = 5'h12;
   localparam logic [4:0] CMD_VFL_LAST = 5'h16;
   localparam logic [4:0] CMD_SHIP = 5'h17;
   localparam logic [4:0] CMD_AR_OFF = 5'h18;
   localparam logic [4:0] CMD_AR_ON = 5'h19;
   localparam logic [4:0] CMD_WD_OFF = 5'h1a;
   localparam logic [4:0] CMD_WD_ON = 5'h1b;
   localparam logic [1:0] A_CFG = 2'h0;
   localparam logic [1:0] A_STAT = 2'h1;
   localparam logic [1:0] A_CMD = 2'h2;

   typedef struct packed {
      logic [3:0] sw;
      logic tap;
      logic [1:0] eoc;
      logic [1:0] ocp;
      logic [2:0] vfl;
      logic ship;
      logic arech;
      logic wdog;
   } cc_cfg_t;
   localparam cc_cfg_t CFG_RST = '{sw: 4'h5, tap: 1'b0, eoc: 2'h1, ocp: 2'h0,
      vfl: 3'h0, ship: 1'b0, arech: 1'b0, wdog: 1'b0};

   typedef struct packed {
      logic ntc, therm, below_pre, tmo, ovchg, chrg, eoc;
      logic rech_low, bat_wake_ok, vin_ok, wake, kick, charge_enable_in, single_wire_protocol;
   } cc_pins_t;

   typedef enum logic [2:0] {RS_IDLE, RS_DGL, RS_PEND, RS_PULSE, RS_DONE,
      RS_WDOG} cc_rs_t;

   typedef struct packed {
      cc_pins_t s1, s2, s3, f, fp;
      logic [7:0] div;
      cc_cfg_t cfg;
      cc_cnt_t sw_cnt;
      logic sw_frame;
      logic [4:0] sw_n;
      cc_rs_t rs;
      cc_cnt_t rs_cnt;
      logic pend, nrst;
      logic [2:0] fl_idx;
      cc_cnt_t fl_cnt;
      logic fl_oe_n;
      cc_cnt_t cen_cnt, wk_cnt, ar_cnt;
      logic ntc_stop, restart, tclr, chg_en;
      logic wreq;
      logic [31:0] rdata;
   } cc_st_t;
endpackage

/* verification/cc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ========
// Host side: single wire commands and the reset clear level.
module cc_host_model (
   input wire logic CLK,
   output logic SINGLE_WIRE_PROTOCOL,
   output logic KICK
);
   initial begin
      SINGLE_WIRE_PROTOCOL = 1'b0;
      KICK = 1'b0;
   end

   // Widths are in microseconds at 25 clocks each.
   task automatic drive(input logic lvl, input int us);
      SINGLE_WIRE_PROTOCOL <= lvl;
      repeat (us * 25) @(posedge CLK);
   endtask

   task automatic send_frame(input int n);
      @(posedge CLK);
      drive(1'b1, 350);
      for (int i = 0; i < n; i++) begin
         drive(1'b0, 100);
         drive(1'b1, 100);
      end
      drive(1'b0, 520);
   endtask

   // The clear level is raised right after a pulse falls or right after pending rises, far ahead of the next expiry.
   task automatic set_kick(input logic v);
      @(posedge CLK);
      KICK <= v;
   endtask
endmodule
`default_nettype wire

/* verification/charger_ctrl_single_wire_protocol_reset_wdog_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module charger_ctrl_single_wire_protocol_reset_wdog_bench
import cc_pkg::*;
;
   // ========
   // Short counts keep the run near a hundred thousand clocks.
   localparam cc_cnt_t P_DGL = 19'h0000a;
   localparam cc_cnt_t P_RST = 19'h00018;
   localparam cc_cnt_t P_WK = 19'h00008;
   localparam int TC = int'(TICK_CYC);
   localparam int T_DGL = int'(P_DGL) * TC;
   localparam int T_RST = int'(P_RST) * TC;
   localparam int LIM = T_RST + TC * 2;
   logic CLK, NRST, rd, wr, wait_r, oe_n, nrst_o, pend, en, rstrt, tclr, sw, kick, prev_n;
   logic flag_d;
   logic [1:0] adr;
   logic [31:0] wdat, rdat, got;
   cc_pins_t drv, pins;
   cc_cfg_t cfg_o, exp;
   int failures, n_compared, cyc, falls, fall_at, n_rs, n_clr, k, f, p;

   cc_charger_ctrl #(.DGL_TICKS(P_DGL), .RST_TICKS(P_RST), .WAKE_TICKS(P_WK),
      .RECH_TICKS(P_WK)) uut (.CLK(CLK), .NRST(NRST), .PINS(pins), .AVS_ADDRESS(adr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wait_r), .CFG_OUT(cfg_o), .STATUS_FLAG_OUT(flag_d),
      .STATUS_FLAG_OE_N(oe_n), .HOST_RESET_OUT_N(nrst_o), .RESET_PENDING_OUT(pend),
      .CHARGER_EN_OUT(en), .CHARGER_RESTART_OUT(rstrt), .TIMER_CLEAR_OUT(tclr));
   cc_host_model host (.CLK(CLK), .SINGLE_WIRE_PROTOCOL(sw), .KICK(kick));

   always_comb begin
      pins = drv;
      pins.single_wire_protocol = sw;
      pins.kick = kick;
   end

   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   // ========
   // Event counters and the hang limit.
   always @(posedge CLK) begin
      cyc++;
      if (prev_n === 1'b1 && nrst_o === 1'b0) begin
         falls++;
         fall_at = cyc;
      end
      prev_n = nrst_o;
      if (rstrt === 1'b1) n_rs++;
      if (tclr === 1'b1) n_clr++;
      if (cyc == 100000) begin
         failures++;
         tally_and_finish();
      end
   end

   // ========
   // Helpers.
   task automatic tally_and_finish();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic in_rng(input string what, input int v, input int lo, input int hi);
      check(what, {31'h0, v >= lo && v <= hi}, 32'h1);
   endtask

   task automatic ticks(input int n);
      repeat (n * TC) @(posedge CLK);
   endtask

   // The wait returns the cycles taken, or the limit when no pulse came.
   task automatic wait_fall(input int lim);
      k = 0;
      f = falls;
      while (falls == f && k < lim) begin
         @(posedge CLK);
         k++;
      end
   endtask

   task automatic low_len();
      k = 0;
      while (nrst_o !== 1'b1 && k < TC * 8) begin
         @(posedge CLK);
         k++;
      end
   endtask

   task automatic wait_pend();
      k = 0;
      while (pend !== 1'b1 && k < T_DGL + TC * 2) begin
         @(posedge CLK);
         k++;
      end
   endtask

   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
      @(posedge CLK);
      wr <= w;
      rd <= ~w;
      adr <= a;
      wdat <= d;
      do @(posedge CLK); while (wait_r !== 1'b0);
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   function automatic cc_cfg_t model(input cc_cfg_t c, input int n);
      cc_cfg_t r;
      r = c;
      if (n >= 1 && n <= 8) r.sw[(n - 1) / 2] = ~n[0];
      else if (n == 9 || n == 10) r.tap = (n == 10);
      else if (n >= 11 && n <= 13) r.eoc = 2'(n - 11);
      else if (n >= 14 && n <= 17) r.ocp = 2'(n - 14);
      else if (n >= 18 && n <= 22) r.vfl = 3'(n - 18);
      else if (n == 23) r.ship = 1'b1;
      else if (n == 24 || n == 25) r.arech = (n == 25);
      else if (n == 26 || n == 27) r.wdog = (n == 27);
      return r;
   endfunction

   task automatic cmd(input int n);
      bus(1'b1, A_CMD, 32'(n));
      exp = model(exp, n);
   endtask

   task automatic chk_cfg();
      bus(1'b0, A_CFG, 32'h0);
      check("cfg read", got, 32'(exp));
      check("cfg port", 32'(cfg_o), 32'(exp));
   endtask

   task automatic set_ev(input int b, input logic v, input int want);
      drv[b] <= v;
      repeat (10) @(posedge CLK);
      bus(1'b0, A_STAT, 32'h0);
      check("rate index", 32'(got[7:5]), 32'(want));
   endtask

   // ========
   // Scenarios.
   task automatic t_regs();
      bus(1'b1, A_CFG, 32'h0);
      exp = '0;
      bus(1'b1, 2'h3, 32'hffffffff);
      bus(1'b1, A_STAT, 32'hffffffff);
      bus(1'b0, 2'h3, 32'h0);
      check("unmapped read", got, 32'h0);
      chk_cfg();
      for (int n = 0; n < 29; n++) begin
         if (n != 23 && n != 27) begin
            cmd(n);
            chk_cfg();
         end
      end
   endtask

   task automatic t_reset();
      drv.vin_ok <= 1'b1;
      wait_pend();
      in_rng("pending delay", k, T_DGL - TC, T_DGL + TC);
      wait_fall(LIM);
      in_rng("reset delay", k, T_RST - TC, T_RST + TC);
      low_len();
      in_rng("reset width", k, TC * 3 - 5, TC * 3 + 5);
      check("pending after", {31'h0, pend}, 32'h0);
      wait_fall(LIM);
      check("single pulse", 32'(k), 32'(LIM));
   endtask

   task automatic t_flag();
      check("flag idle", {31'h0, oe_n}, 32'h0);
      check("flag data", {31'h0, flag_d}, 32'h0);
      for (int i = 0; i < 7; i++) set_ev(7 + i, 1'b1, i);
      for (int i = 6; i > 0; i--) set_ev(7 + i, 1'b0, i - 1);
   endtask

   task automatic t_cen();
      check("enable high", {31'h0, en}, 32'h1);
      f = n_clr;
      drv.ntc <= 1'b1;
      repeat (10) @(posedge CLK);
      drv.charge_enable_in <= 1'b0;
      repeat (20) @(posedge CLK);
      check("enable low", {31'h0, en}, 32'h0);
      check("timer clear", 32'(n_clr - f), 32'h1);
      drv.ntc <= 1'b0;
      drv.charge_enable_in <= 1'b1;
      repeat (20) @(posedge CLK);
      drv.charge_enable_in <= 1'b0;
      repeat (20) @(posedge CLK);
      check("no clear", 32'(n_clr - f), 32'h1);
      drv.charge_enable_in <= 1'b1;
   endtask

   task automatic t_rech();
      cmd(25);
      drv.rech_low <= 1'b1;
      f = n_rs;
      ticks(int'(P_WK) - 2);
      check("no early restart", 32'(n_rs - f), 32'h0);
      ticks(6);
      check("auto restart", {31'h0, n_rs > f}, 32'h1);
      drv.ovchg <= 1'b1;
      ticks(2);
      f = n_rs;
      ticks(int'(P_WK) + 4);
      check("overcharge blocks", 32'(n_rs - f), 32'h0);
      drv.ovchg <= 1'b0;
      drv.rech_low <= 1'b0;
      drv.eoc <= 1'b0;
   endtask

   task automatic t_early();
      drv.vin_ok <= 1'b0;
      ticks(2);
      drv.vin_ok <= 1'b1;
      wait_pend();
      host.set_kick(1'b1);
      wait_fall(20);
      in_rng("early reset", k, 1, 19);
      ticks(6);
      check("pending cleared", {31'h0, pend}, 32'h0);
      host.set_kick(1'b0);
   endtask

   task automatic t_wake();
      cmd(23);
      chk_cfg();
      drv.wake <= 1'b1;
      drv.bat_wake_ok <= 1'b1;
      ticks(int'(P_WK) + 4);
      check("wake ignored", {31'h0, cfg_o.ship}, 32'h1);
      drv.vin_ok <= 1'b0;
      drv.bat_wake_ok <= 1'b0;
      ticks(int'(P_WK) + 4);
      check("wake low battery", {31'h0, cfg_o.ship}, 32'h1);
      check("flag released", {31'h0, oe_n}, 32'h1);
      drv.wake <= 1'b0;
      ticks(2);
      drv.wake <= 1'b1;
      drv.bat_wake_ok <= 1'b1;
      ticks(int'(P_WK) + 4);
      check("wake exit", {31'h0, cfg_o.ship}, 32'h0);
      exp.ship = 1'b0;
      drv.wake <= 1'b0;
   endtask

   task automatic t_wdog();
      cmd(27);
      chk_cfg();
      wait_fall(LIM);
      p = fall_at;
      low_len();
      in_rng("battery reset width", k, TC * 5 - 5, TC * 5 + 5);
      wait_fall(LIM);
      in_rng("watchdog period", fall_at - p, T_RST - TC, T_RST + TC);
      host.set_kick(1'b1);
      wait_fall(LIM);
      check("pulse skipped", 32'(k), 32'(LIM));
      host.set_kick(1'b0);
      wait_fall(LIM);
      in_rng("pulse resumes", k, 1, T_RST);
      low_len();
      cmd(26);
      chk_cfg();
      wait_fall(LIM);
      check("watchdog off", 32'(k), 32'(LIM));
   endtask

   task automatic t_wire();
      host.send_frame(1);
      exp = model(exp, 1);
      check("wire command", 32'(cfg_o), 32'(exp));
   endtask

   initial begin
      NRST = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 2'h0;
      wdat = 32'h0;
      drv = '0;
      drv.charge_enable_in = 1'b1;
      prev_n = 1'b1;
      exp = CFG_RST;
      repeat (12) @(posedge CLK);
      check("cfg at reset", 32'(cfg_o), 32'(CFG_RST));
      check("flag at reset", {31'h0, oe_n}, 32'h1);
      check("reset idle", {31'h0, nrst_o, pend}, 32'h2);
      NRST <= 1'b1;
      t_regs();
      t_reset();
      t_flag();
      t_cen();
      t_rech();
      t_early();
      t_wake();
      t_wdog();
      t_wire();
      tally_and_finish();
   end
endmodule
`default_nettype wire
